// ===== design/ipe_noise.sv
// noise rejector: passes a level only after two agreeing tick samples
module ipe_noise #(
  parameter int W        = 9,
  parameter int TICK_CYC = ipe_pkg::REJECT_CYCLES / 2
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [ipe_pkg::REJ_CNT_W-1:0] cnt_reg;
  logic                          tick_reg;
  logic [W-1:0]                  smp_reg;

  // -----------------------------------------------------------
  // tick divider
  // -----------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (cnt_reg ==
                 ipe_pkg::REJ_CNT_W'(TICK_CYC - 1)) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------
  // filter
  // -----------------------------------------------------------
  // a change is seen after at most two ticks, under the limit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp_reg <= '0;
      dout    <= '0;
    end else if (tick_reg) begin
      smp_reg <= din;
      for (int i = 0; i < W; i++) begin
        if (din[i] == smp_reg[i]) begin
          dout[i] <= din[i];
        end
      end
    end
  end
endmodule

// ===== design/ipe_pkg.sv
// constants shared by the input port edge interrupt block
package ipe_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_G0_DATA   = 10'h2e3;
  localparam logic [9:0] IDX_G0_EDGE   = 10'h2e4;
  localparam logic [9:0] IDX_G0_EN     = 10'h2e5;
  localparam logic [9:0] IDX_SINGLE    = 10'h2e7;
  localparam logic [9:0] IDX_FLAGS_A   = 10'h2ea;
  localparam logic [9:0] IDX_FLAGS_B   = 10'h2f3;
  localparam logic [9:0] IDX_G2_DATA   = 10'h2f4;
  localparam logic [9:0] IDX_G2_EN     = 10'h2f5;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SGL_DATA_BIT  = 0;
  localparam int SGL_EDGE_BIT  = 1;
  localparam int SGL_EN_BIT    = 2;
  localparam int FLA_G0_BIT    = 2;
  localparam int FLA_G1_BIT    = 3;
  localparam int FLB_G2_BIT    = 1;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_NIBBLE  = 4'h0;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int REJECT_TIME_US   = 1000;
  // longest delay, so round down
  localparam int REJECT_CYCLES    =
    (REJECT_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int REJ_CNT_W        = 18;
  // ---------------------------------------------------------------
  // bus slave states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IPE_IDLE = 2'b00,
    IPE_WAIT = 2'b01,
    IPE_RESP = 2'b11
  } ipe_bus_state_t;
endpackage

// ===== design/ipe_sync.sv
// two-stage synchroniser for the input terminals
module ipe_sync #(
  parameter int W = 9
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1_reg <= '0;
      dout       <= '0;
    end else begin
      stage1_reg <= din;
      dout       <= stage1_reg;
    end
  end
endmodule

// ===== design/ipe_top.sv
// input port with per-group edge interrupt flags, ahb-lite slave
//
// Contract
// - each of nine data bits reads 1 for high terminal, 0 for low
// - data bits are read only; writes change nothing
// - edge select 1 arms falling, 0 rising; select bits readable
// - reset clears all five edge select bits
// - each of nine inputs has a readable enable bit, 1 enables
// - reset clears all nine enable bits
// - three flags: first group, single input, third group
// - flags read 1 after event, clear on read, ignore writes
// - reset clears all three flags
// - noise rejector may delay flag setting by up to 1 ms
// - a late set after a read still leaves the flag set
// - re-enabling an input held active sets the flag again
// - match to mismatch triggers; mismatch to mismatch does not
// - third group triggers when enabled inputs go all zero to any one
// - disabled inputs take no part in any condition
//
// Chosen here: the AHB-Lite interface to the registers.
module ipe_top #(
  parameter int       REJECT_CYCLES = ipe_pkg::REJECT_CYCLES,
  parameter bit [2:0] NOISE_SEL     = 3'h0
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  first_group_inputs,
  input  wire logic        single_bit_input,
  input  wire logic [3:0]  third_group_inputs
);
  // -----------------------------------------------------------
  // terminal synchronisation and noise rejection
  // -----------------------------------------------------------
  logic [8:0] pins_sync;
  logic [8:0] pins_filt;
  logic [8:0] pins_irq;

  ipe_sync #(
    .W (9)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({third_group_inputs, single_bit_input,
               first_group_inputs}),
    .dout    (pins_sync)
  );

  ipe_noise #(
    .W        (9),
    .TICK_CYC (REJECT_CYCLES / 2)
  ) u_noise (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (pins_sync),
    .dout    (pins_filt)
  );

  // per-group choice between direct and filtered levels
  always_comb begin
    pins_irq[3:0] = NOISE_SEL[0] ? pins_filt[3:0] : pins_sync[3:0];
    pins_irq[4]   = NOISE_SEL[1] ? pins_filt[4]   : pins_sync[4];
    pins_irq[8:5] = NOISE_SEL[2] ? pins_filt[8:5] : pins_sync[8:5];
  end

  // -----------------------------------------------------------
  // control registers
  // -----------------------------------------------------------
  logic [3:0] first_group_edge_select;
  logic       single_input_edge_select;
  logic [3:0] first_group_irq_enable;
  logic       single_input_irq_enable;
  logic [3:0] third_group_irq_enable;
  logic       first_group_factor_flag;
  logic       single_input_factor_flag;
  logic       third_group_factor_flag;

  // -----------------------------------------------------------
  // bus slave
  // -----------------------------------------------------------
  ipe_pkg::ipe_bus_state_t st_reg;
  logic [9:0]  idx_reg;
  logic        wr_reg;
  logic        accept;
  logic        do_wr;
  logic        do_rd;
  logic [31:0] rd_next;

  assign accept = hsel && htrans[1] && hready;
  assign do_wr  = (st_reg == ipe_pkg::IPE_WAIT) && wr_reg;
  assign do_rd  = (st_reg == ipe_pkg::IPE_WAIT) && !wr_reg;

  function automatic logic wr_hit(input logic [9:0] idx);
    wr_hit = do_wr && (idx_reg == idx);
  endfunction

  function automatic logic rd_hit(input logic [9:0] idx);
    rd_hit = do_rd && (idx_reg == idx);
  endfunction

  // one wait state gives the read data a flop to come from
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg    <= ipe_pkg::IPE_IDLE;
      idx_reg   <= '0;
      wr_reg    <= 1'b0;
      hreadyout <= 1'b1;
    end else begin
      case (st_reg)
        ipe_pkg::IPE_IDLE, ipe_pkg::IPE_RESP: begin
          if (accept) begin
            st_reg    <= ipe_pkg::IPE_WAIT;
            // upper bits set: index no register can hold
            idx_reg   <= (haddr[31:12] == 20'h00000) ?
                         haddr[11:2] : 10'h3ff;
            wr_reg    <= hwrite;
            hreadyout <= 1'b0;
          end else begin
            st_reg    <= ipe_pkg::IPE_IDLE;
          end
        end
        ipe_pkg::IPE_WAIT: begin
          st_reg    <= ipe_pkg::IPE_RESP;
          hreadyout <= 1'b1;
        end
        default: begin
          st_reg    <= ipe_pkg::IPE_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // -----------------------------------------------------------
  // register writes
  // -----------------------------------------------------------
  // data and flag addresses have no write path at all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_group_edge_select  <= ipe_pkg::RST_NIBBLE;
      single_input_edge_select <= 1'b0;
    end else begin
      if (wr_hit(ipe_pkg::IDX_G0_EDGE)) begin
        first_group_edge_select <= hwdata[3:0];
      end
      if (wr_hit(ipe_pkg::IDX_SINGLE)) begin
        single_input_edge_select <= hwdata[ipe_pkg::SGL_EDGE_BIT];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_group_irq_enable  <= ipe_pkg::RST_NIBBLE;
      single_input_irq_enable <= 1'b0;
      third_group_irq_enable  <= ipe_pkg::RST_NIBBLE;
    end else begin
      if (wr_hit(ipe_pkg::IDX_G0_EN)) begin
        first_group_irq_enable <= hwdata[3:0];
      end
      if (wr_hit(ipe_pkg::IDX_SINGLE)) begin
        single_input_irq_enable <= hwdata[ipe_pkg::SGL_EN_BIT];
      end
      if (wr_hit(ipe_pkg::IDX_G2_EN)) begin
        third_group_irq_enable <= hwdata[3:0];
      end
    end
  end

  // -----------------------------------------------------------
  // interrupt conditions
  // -----------------------------------------------------------
  // masked bits count as matching, or as zero in the third group, so they never trigger
  logic g0_match;
  logic g1_match;
  logic g2_any;
  logic g0_match_reg;
  logic g1_match_reg;
  logic g2_any_reg;
  logic g0_evt;
  logic g1_evt;
  logic g2_evt;

  assign g0_match = &(~first_group_irq_enable |
                      ~(pins_irq[3:0] ^ first_group_edge_select));
  assign g1_match = ~single_input_irq_enable |
                    (pins_irq[4] == single_input_edge_select);
  assign g2_any   = |(third_group_irq_enable & pins_irq[8:5]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      g0_match_reg <= 1'b1;
      g1_match_reg <= 1'b1;
      g2_any_reg   <= 1'b0;
    end else begin
      g0_match_reg <= g0_match;
      g1_match_reg <= g1_match;
      g2_any_reg   <= g2_any;
    end
  end

  // re-enabling an active input also makes this transition
  assign g0_evt = g0_match_reg && !g0_match;
  assign g1_evt = g1_match_reg && !g1_match;
  assign g2_evt = !g2_any_reg && g2_any;

  // -----------------------------------------------------------
  // factor flags
  // -----------------------------------------------------------
  // set beats the read clear, so a late set is never lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_group_factor_flag  <= 1'b0;
      single_input_factor_flag <= 1'b0;
    end else begin
      if (g0_evt) begin
        first_group_factor_flag <= 1'b1;
      end else if (rd_hit(ipe_pkg::IDX_FLAGS_A)) begin
        first_group_factor_flag <= 1'b0;
      end
      if (g1_evt) begin
        single_input_factor_flag <= 1'b1;
      end else if (rd_hit(ipe_pkg::IDX_FLAGS_A)) begin
        single_input_factor_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      third_group_factor_flag <= 1'b0;
    end else if (g2_evt) begin
      third_group_factor_flag <= 1'b1;
    end else if (rd_hit(ipe_pkg::IDX_FLAGS_B)) begin
      third_group_factor_flag <= 1'b0;
    end
  end

  // -----------------------------------------------------------
  // read data
  // -----------------------------------------------------------
  always_comb begin
    rd_next = ipe_pkg::RST_WORD;
    case (idx_reg)
      ipe_pkg::IDX_G0_DATA: rd_next[3:0] = pins_sync[3:0];
      ipe_pkg::IDX_G0_EDGE: rd_next[3:0] = first_group_edge_select;
      ipe_pkg::IDX_G0_EN:   rd_next[3:0] = first_group_irq_enable;
      ipe_pkg::IDX_SINGLE: begin
        rd_next[ipe_pkg::SGL_DATA_BIT] = pins_sync[4];
        rd_next[ipe_pkg::SGL_EDGE_BIT] = single_input_edge_select;
        rd_next[ipe_pkg::SGL_EN_BIT]   = single_input_irq_enable;
      end
      ipe_pkg::IDX_FLAGS_A: begin
        rd_next[ipe_pkg::FLA_G0_BIT] = first_group_factor_flag;
        rd_next[ipe_pkg::FLA_G1_BIT] = single_input_factor_flag;
      end
      ipe_pkg::IDX_FLAGS_B:
        rd_next[ipe_pkg::FLB_G2_BIT] = third_group_factor_flag;
      ipe_pkg::IDX_G2_DATA: rd_next[3:0] = pins_sync[8:5];
      ipe_pkg::IDX_G2_EN:   rd_next[3:0] = third_group_irq_enable;
      default:              rd_next = ipe_pkg::RST_WORD;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= ipe_pkg::RST_WORD;
    end else if (do_rd) begin
      hrdata <= rd_next;
    end
  end

  // -----------------------------------------------------------
  // assertions
  // -----------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_FLAG_SET_WINS: assert property (
    g0_evt && rd_hit(ipe_pkg::IDX_FLAGS_A) |=> first_group_factor_flag)
    else $error("first group flag lost to a read clear");

  AST_READ_CLEARS: assert property (
    rd_hit(ipe_pkg::IDX_FLAGS_A) && !g0_evt && !g1_evt
    |=> !first_group_factor_flag && !single_input_factor_flag
        && hreadyout)
    else $error("flag read did not clear the flags");

  AST_FLAG2_READ: assert property (
    rd_hit(ipe_pkg::IDX_FLAGS_B)
    |=> hrdata[ipe_pkg::FLB_G2_BIT] == $past(third_group_factor_flag))
    else $error("third group flag read back wrong");

  AST_EN_WRITE: assert property (
    wr_hit(ipe_pkg::IDX_G2_EN)
    |=> third_group_irq_enable == $past(hwdata[3:0]))
    else $error("third group enable not written");

  AST_SEL_WRITE: assert property (
    wr_hit(ipe_pkg::IDX_G0_EDGE)
    |=> first_group_edge_select == $past(hwdata[3:0]))
    else $error("edge select not written");

  AST_DATA_RO: assert property (
    wr_hit(ipe_pkg::IDX_G0_DATA) || wr_hit(ipe_pkg::IDX_FLAGS_A)
    |=> $stable(first_group_edge_select)
        && $stable(first_group_irq_enable)
        && (first_group_factor_flag <= $past(first_group_factor_flag)
            || $past(g0_evt)))
    else $error("write to read-only address changed state");

  AST_DATA_READ: assert property (
    rd_hit(ipe_pkg::IDX_G2_DATA) |=> hrdata[3:0] == $past(pins_sync[8:5]))
    else $error("third group data read wrong");

  AST_G0_MISMATCH: assert property (
    $rose(first_group_factor_flag)
    |-> $past(|(first_group_irq_enable &
                (pins_irq[3:0] ^ first_group_edge_select))))
    else $error("first group flag set without enabled mismatch");

  AST_G2_CAUSE: assert property (
    !$past(|(third_group_irq_enable & pins_irq[8:5]))
    && |(third_group_irq_enable & pins_irq[8:5])
    |=> third_group_factor_flag)
    else $error("third group rise from all zero left no flag");

  AST_ONE_WAIT: assert property (
    accept && st_reg != ipe_pkg::IPE_WAIT |=> !hreadyout ##1 hreadyout)
    else $error("slave did not answer after one wait state");

  COV_G0_FLAG: cover property (g0_evt ##[1:20] rd_hit(ipe_pkg::IDX_FLAGS_A));
  COV_G2_FLAG: cover property (g2_evt);
  COV_SET_ON_READ: cover property (g1_evt && rd_hit(ipe_pkg::IDX_FLAGS_A));
  COV_BACK2BACK: cover property (accept ##2 accept);
endmodule

// ===== test/ipe_keys.sv
// key switch model driving the nine input terminals
module ipe_keys (
  input  wire logic       hclk,
  input  wire logic [8:0] level,
  input  wire logic [3:0] bounce,
  output logic      [3:0] first_group_inputs,
  output logic            single_bit_input,
  output logic      [3:0] third_group_inputs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] pins  = 9'h0;
  logic [8:0] last  = 9'h0;
  logic [8:0] moved = 9'h0;
  logic [3:0] left  = 4'h0;
  // ---------------------------------------------------------------
  // contact chatter
  // ---------------------------------------------------------------
  // real contacts chatter on the bits that moved before they settle
  always @(posedge hclk) begin
    if (level != last) begin
      last  <= level;
      moved <= level ^ last;
      left  <= bounce;
      pins  <= (bounce == 4'h0) ? level : last;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
      pins <= (left == 4'h1) ? last : pins ^ moved;
    end
  end
  assign first_group_inputs = pins[3:0];
  assign single_bit_input   = pins[4];
  assign third_group_inputs = pins[8:5];
endmodule

// ===== test/testbench.sv
// self-checking bench for the input port edge interrupt block
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
  end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REJ = 16;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [8:0]  level   = 9'h0;
  logic [3:0]  bounce  = 4'h0;
  logic [3:0]  g0_pins;
  logic        s_pin;
  logic [3:0]  g2_pins;
  logic [31:0] rd;
  logic [3:0]  sh_edge0 = 4'h0;
  logic [3:0]  sh_en0   = 4'h0;
  logic [3:0]  sh_en2   = 4'h0;
  logic        sh_es    = 1'b0;
  logic        sh_en1   = 1'b0;
  int          fails    = 0;
  int          compares = 0;
  int          cycles   = 0;
  integer      seed     = 32'h0a43a57d;
  logic [9:0]  regs [8] = '{ipe_pkg::IDX_G0_DATA, ipe_pkg::IDX_G0_EDGE,
    ipe_pkg::IDX_G0_EN, ipe_pkg::IDX_SINGLE, ipe_pkg::IDX_G2_DATA,
    ipe_pkg::IDX_G2_EN, 10'h3ff, 10'h2e6};
  localparam logic [31:0] FA0 = 32'h1 << ipe_pkg::FLA_G0_BIT;
  localparam logic [31:0] FA1 = 32'h1 << ipe_pkg::FLA_G1_BIT;
  localparam logic [31:0] FB2 = 32'h1 << ipe_pkg::FLB_G2_BIT;

  always #2 hclk = ~hclk;

  ipe_keys keys (.hclk(hclk), .level(level), .bounce(bounce),
    .first_group_inputs(g0_pins), .single_bit_input(s_pin),
    .third_group_inputs(g2_pins));

  ipe_top #(.REJECT_CYCLES(REJ), .NOISE_SEL(3'h4)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .first_group_inputs(g0_pins), .single_bit_input(s_pin),
    .third_group_inputs(g2_pins));

  // ---------------------------------------------------------------
  // bus master and expectations
  // ---------------------------------------------------------------
  task automatic xfer(input logic [9:0] idx, input logic wr,
                      input logic [3:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {28'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic wreg(input logic [9:0] idx, input logic [3:0] v);
    xfer(idx, 1'b1, v);
    case (idx)
      ipe_pkg::IDX_G0_EDGE: sh_edge0 = v;
      ipe_pkg::IDX_G0_EN:   sh_en0 = v;
      ipe_pkg::IDX_SINGLE:  {sh_en1, sh_es} = v[2:1];
      ipe_pkg::IDX_G2_EN:   sh_en2 = v;
      default: ;
    endcase
  endtask

  function automatic logic [31:0] exp_reg(input logic [9:0] idx);
    case (idx)
      ipe_pkg::IDX_G0_DATA: return {28'h0, level[3:0]};
      ipe_pkg::IDX_G0_EDGE: return {28'h0, sh_edge0};
      ipe_pkg::IDX_G0_EN:   return {28'h0, sh_en0};
      ipe_pkg::IDX_SINGLE:  return {29'h0, sh_en1, sh_es, level[4]};
      ipe_pkg::IDX_G2_DATA: return {28'h0, level[8:5]};
      ipe_pkg::IDX_G2_EN:   return {28'h0, sh_en2};
      default: return 32'h0;
    endcase
  endfunction

  task automatic chk_all();
    for (int j = 0; j < 8; j++) begin
      xfer(regs[j], 1'b0, 4'h0);
      `CHK(rd, exp_reg(regs[j]))
    end
  endtask

  task automatic flag(input logic [9:0] idx, input logic [31:0] e);
    xfer(idx, 1'b0, 4'h0);
    `CHK(rd, e)
  endtask

  task automatic pins(input logic [8:0] v);
    @(posedge hclk);
    level <= v;
    repeat (6) @(posedge hclk);
  endtask

  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask

  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // a hung handshake ends the run here
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    chk_all();
    flag(ipe_pkg::IDX_FLAGS_A, 32'h0);
    flag(ipe_pkg::IDX_FLAGS_B, 32'h0);
    tdone("reset values");
    // first group enables cleared before its selects change; single input register written whole
    for (int i = 0; i < 12; i++) begin
      pins(9'($random(seed)));
      wreg(ipe_pkg::IDX_G0_DATA, 4'($random(seed)));
      wreg(ipe_pkg::IDX_G2_DATA, 4'($random(seed)));
      wreg(ipe_pkg::IDX_G0_EN, 4'h0);
      wreg(ipe_pkg::IDX_G0_EDGE, 4'($random(seed)));
      wreg(ipe_pkg::IDX_G0_EN, 4'($random(seed)));
      wreg(ipe_pkg::IDX_SINGLE, 4'($random(seed)));
      wreg(ipe_pkg::IDX_G2_EN, 4'($random(seed)));
      chk_all();
    end
    tdone("data and readback");
    wreg(ipe_pkg::IDX_G0_EN, 4'h0);
    wreg(ipe_pkg::IDX_SINGLE, 4'h0);
    wreg(ipe_pkg::IDX_G2_EN, 4'h0);
    pins(9'h000);
    wreg(ipe_pkg::IDX_G0_EDGE, 4'h0);
    wreg(ipe_pkg::IDX_G0_EN, 4'he);
    xfer(ipe_pkg::IDX_FLAGS_A, 1'b0, 4'h0);
    xfer(ipe_pkg::IDX_FLAGS_B, 1'b0, 4'h0);
    pins(9'h001);
    flag(ipe_pkg::IDX_FLAGS_A, 32'h0);
    pins(9'h003);
    wreg(ipe_pkg::IDX_FLAGS_A, 4'h0);
    flag(ipe_pkg::IDX_FLAGS_A, FA0);
    flag(ipe_pkg::IDX_FLAGS_A, 32'h0);
    pins(9'h007);
    flag(ipe_pkg::IDX_FLAGS_A, 32'h0);
    wreg(ipe_pkg::IDX_G0_EN, 4'h0);
    wreg(ipe_pkg::IDX_G0_EDGE, 4'hf);
    pins(9'h00f);
    wreg(ipe_pkg::IDX_G0_EN, 4'hf);
    flag(ipe_pkg::IDX_FLAGS_A, 32'h0);
    pins(9'h00b);
    flag(ipe_pkg::IDX_FLAGS_A, FA0);
    wreg(ipe_pkg::IDX_G0_EN, 4'h0);
    tdone("first group");
    for (int e = 0; e < 2; e++) begin
      wreg(ipe_pkg::IDX_SINGLE, {2'b00, e[0], 1'b0});
      pins({e[0], 4'h0});
      wreg(ipe_pkg::IDX_SINGLE, {2'b01, e[0], 1'b0});
      flag(ipe_pkg::IDX_FLAGS_A, 32'h0);
      pins({~e[0], 4'h0});
      flag(ipe_pkg::IDX_FLAGS_A, FA1);
      wreg(ipe_pkg::IDX_SINGLE, {2'b00, e[0], 1'b0});
      flag(ipe_pkg::IDX_FLAGS_A, 32'h0);
      wreg(ipe_pkg::IDX_SINGLE, {2'b01, e[0], 1'b0});
      flag(ipe_pkg::IDX_FLAGS_A, FA1);
    end
    wreg(ipe_pkg::IDX_SINGLE, 4'h0);
    tdone("single input");
    pins(9'h000);
    wreg(ipe_pkg::IDX_G2_EN, 4'h6);
    xfer(ipe_pkg::IDX_FLAGS_B, 1'b0, 4'h0);
    bounce <= 4'h3;
    pins(9'h020);
    repeat (REJ + 6) @(posedge hclk);
    flag(ipe_pkg::IDX_FLAGS_B, 32'h0);
    @(posedge hclk);
    level <= 9'h060;
    // this read lands before the filtered set arrives
    flag(ipe_pkg::IDX_FLAGS_B, 32'h0);
    repeat (REJ + 6) @(posedge hclk);
    flag(ipe_pkg::IDX_FLAGS_B, FB2);
    pins(9'h0e0);
    repeat (REJ + 6) @(posedge hclk);
    flag(ipe_pkg::IDX_FLAGS_B, 32'h0);
    pins(9'h020);
    repeat (REJ + 6) @(posedge hclk);
    flag(ipe_pkg::IDX_FLAGS_B, 32'h0);
    tdone("third group");
    end_of_test();
  end
endmodule
